// [rtl/dcf_fifo.sv]
// dual-clock 512x18 fifo with flags, sampled on the system clock
`timescale 1ns/1ps

module dcf_fifo #(
	parameter int WIDTH = dcf_pkg::DCF_WIDTH,
	parameter int AW    = dcf_pkg::DCF_AW
) (
	// system
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	// write side pins
	input  wire logic                          wr_clk_i,
	input  wire logic [WIDTH-1:0]              wr_word_i,
	input  wire logic                          thresh_prog_n_i,
	input  wire logic                          fifo_rst_n_i,
	// read side pins
	input  wire logic                          rd_clk_i,
	input  wire logic                          out_en_n_i,
	output logic      [WIDTH-1:0]              rd_word_o,
	output logic                               rd_word_oe_o,
	// flags
	output logic                               empty_n_o,
	output logic                               full_n_o,
	output logic                               half_flag_o,
	output logic                               almost_flag_o,
	// wishbone slave
	input  wire logic                          cyc_i,
	input  wire logic                          stb_i,
	input  wire logic                          we_i,
	input  wire logic [dcf_pkg::DCF_ADR_W-1:0] adr_i,
	input  wire logic [3:0]                    sel_i,
	input  wire logic [31:0]                   dat_i,
	output logic      [31:0]                   dat_o,
	output logic                               ack_o
);
	localparam int CW = dcf_pkg::DCF_CW;
	localparam int TW = dcf_pkg::DCF_TW;

	// pin synchronisers; stage one is read by stage two only
	// pin levels must hold one full clk or an edge is lost
	logic [dcf_pkg::SY_N-1:0] sy1_r;
	logic [dcf_pkg::SY_N-1:0] sy2_r;
	logic [1:0]               clk_prev_r;
	logic [WIDTH-1:0]         wd1_r;
	logic [WIDTH-1:0]         wd2_r;

	// storage and state
	logic [WIDTH-1:0]         mem [dcf_pkg::DCF_DEPTH];
	logic [AW-1:0]            wr_ptr_r;
	logic [AW-1:0]            rd_ptr_r;
	logic [CW-1:0]            cnt_r;
	logic [CW-1:0]            cnt_nxt;
	logic [TW-1:0]            ae_r;
	logic [TW-1:0]            af_r;
	dcf_pkg::dcf_prog_t       pst_r;
	dcf_pkg::dcf_prog_t       pst_nxt;
	logic                     soft_clr_r;

	// decoded events
	wire                      wr_edge;
	wire                      rd_edge;
	wire                      clr_w;
	wire                      pen_low;
	wire                      prog_hit;
	wire                      wr_do;
	wire                      rd_do;
	wire [CW-1:0]             af_lvl;
	wire                      alm_nxt;
	wire                      win_open;
	wire [CW-1:0]             cnt_inc;
	wire [CW-1:0]             cnt_dec;
	wire [CW-1:0]             ae_lvl;
	wire                      emp_nxt;
	wire                      ful_nxt;
	wire                      hlf_nxt;
	wire [WIDTH-1:0]          head_w;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sy1_r      <= dcf_pkg::SY_IDLE;
			sy2_r      <= dcf_pkg::SY_IDLE;
			clk_prev_r <= 2'h0;
		end else begin
			sy1_r      <= {out_en_n_i, fifo_rst_n_i, thresh_prog_n_i, rd_clk_i, wr_clk_i};
			sy2_r      <= sy1_r;
			clk_prev_r <= {sy2_r[dcf_pkg::SY_RCLK], sy2_r[dcf_pkg::SY_WCLK]};
		end
	end

	// data delayed as far as the clock so it lines up with the edge
	always_ff @(posedge clk_i) begin
		wd1_r <= wr_word_i;
		wd2_r <= wd1_r;
	end

	assign wr_edge = sy2_r[dcf_pkg::SY_WCLK] & ~clk_prev_r[0];
	assign rd_edge = sy2_r[dcf_pkg::SY_RCLK] & ~clk_prev_r[1];
	assign clr_w   = ~sy2_r[dcf_pkg::SY_RST] | soft_clr_r;
	assign pen_low = ~sy2_r[dcf_pkg::SY_PEN];
	assign win_open = (pst_r != dcf_pkg::PG_CLOSED);

	assign prog_hit = wr_edge & pen_low & win_open;
	assign wr_do = wr_edge & full_n_o & ~prog_hit & ~clr_w;
	assign rd_do = rd_edge & empty_n_o & ~clr_w;

	// full blocks writes and empty blocks reads, so the count never wraps
	assign cnt_inc = cnt_r + CW'(1);
	assign cnt_dec = cnt_r - CW'(1);

	always_comb begin
		cnt_nxt = cnt_r;
		if (clr_w) begin
			cnt_nxt = dcf_pkg::DCF_CNT_ZERO;
		end else if (wr_do & ~rd_do) begin
			cnt_nxt = cnt_inc;
		end else if (rd_do & ~wr_do) begin
			cnt_nxt = cnt_dec;
		end
	end

	// programming sequence
	always_comb begin
		pst_nxt = pst_r;
		case (pst_r)
			dcf_pkg::PG_FIRST: begin
				if (prog_hit) begin
					pst_nxt = dcf_pkg::PG_SECOND;
				end else if (wr_do) begin
					pst_nxt = dcf_pkg::PG_CLOSED;
				end
			end
			dcf_pkg::PG_SECOND: begin
				if (prog_hit) begin
					pst_nxt = dcf_pkg::PG_HOLD;
				end else if (wr_do) begin
					pst_nxt = dcf_pkg::PG_CLOSED;
				end
			end
			dcf_pkg::PG_HOLD: begin
				if (wr_do) begin
					pst_nxt = dcf_pkg::PG_CLOSED;
				end
			end
			dcf_pkg::PG_CLOSED: pst_nxt = dcf_pkg::PG_CLOSED;
			default:            pst_nxt = dcf_pkg::PG_CLOSED;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i | clr_w) begin
			pst_r <= dcf_pkg::PG_FIRST;
			ae_r  <= dcf_pkg::DCF_TH_DEF;
			af_r  <= dcf_pkg::DCF_TH_DEF;
		end else begin
			pst_r <= pst_nxt;
			if (prog_hit && pst_r == dcf_pkg::PG_FIRST) begin
				ae_r <= wd2_r[TW-1:0];
				af_r <= wd2_r[TW-1:0];
			end
			if (prog_hit && pst_r == dcf_pkg::PG_SECOND) begin
				af_r <= wd2_r[TW-1:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (wr_do) begin
			mem[wr_ptr_r] <= wd2_r;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i | clr_w) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			cnt_r    <= dcf_pkg::DCF_CNT_ZERO;
		end else begin
			if (wr_do) begin
				wr_ptr_r <= wr_ptr_r + AW'(1);
			end
			if (rd_do) begin
				rd_ptr_r <= rd_ptr_r + AW'(1);
			end
			cnt_r <= cnt_nxt;
		end
	end

	assign ae_lvl  = {{(CW-TW){1'b0}}, ae_r};
	assign af_lvl  = dcf_pkg::DCF_CNT_FULL - {{(CW-TW){1'b0}}, af_r};
	assign alm_nxt = (cnt_nxt <= ae_lvl) | (cnt_nxt >= af_lvl);
	assign emp_nxt = (cnt_nxt != dcf_pkg::DCF_CNT_ZERO);
	assign ful_nxt = (cnt_nxt != dcf_pkg::DCF_CNT_FULL);
	assign hlf_nxt = (cnt_nxt >= dcf_pkg::DCF_CNT_HALF);

	// flags follow the next count so they settle with the pointers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			empty_n_o     <= 1'b0;
			full_n_o      <= 1'b1;
			half_flag_o   <= 1'b0;
			almost_flag_o <= 1'b1;
		end else begin
			empty_n_o     <= emp_nxt;
			full_n_o      <= ful_nxt;
			half_flag_o   <= hlf_nxt;
			almost_flag_o <= alm_nxt;
		end
	end

	// head word shown without a read; lags the pointers by one cycle
	assign head_w = mem[rd_ptr_r];

	// system reset zeroes the head word; the pin reset leaves it alone
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_word_o <= '0;
		end else if (cnt_r != dcf_pkg::DCF_CNT_ZERO) begin
			rd_word_o <= head_w;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_word_oe_o <= 1'b0;
		end else begin
			rd_word_oe_o <= ~sy2_r[dcf_pkg::SY_OE];
		end
	end

	// wishbone slave, one registered answer per request
	wire        wb_req;
	wire        wb_take;
	wire        wb_wr;
	wire        clr_req;
	wire [31:0] stat_w;
	wire [31:0] thr_w;
	wire [31:0] rd_mux;

	assign wb_req  = cyc_i & stb_i & ~ack_o;
	// a write lands on the edge that samples ack high
	assign wb_take = cyc_i & stb_i & ack_o;
	assign wb_wr   = wb_take & we_i & sel_i[0] & (adr_i == dcf_pkg::ADR_CTRL);
	assign clr_req = wb_wr & dat_i[dcf_pkg::CTRL_CLR];
	assign stat_w = {{(32 - dcf_pkg::STAT_CNT - CW){1'b0}}, cnt_r, 12'h000,
		almost_flag_o, half_flag_o, full_n_o, empty_n_o};
	assign thr_w  = {15'h0000, win_open, af_r, ae_r};
	assign rd_mux = (adr_i == dcf_pkg::ADR_STAT) ? stat_w :
		(adr_i == dcf_pkg::ADR_THR) ? thr_w : 32'h0000_0000;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o      <= 1'b0;
			dat_o      <= 32'h0000_0000;
			soft_clr_r <= 1'b0;
		end else begin
			ack_o      <= wb_req;
			dat_o      <= wb_req ? rd_mux : 32'h0000_0000;
			// one-cycle clear, same effect as the reset pin
			soft_clr_r <= clr_req;
		end
	end
endmodule

// [rtl/dcf_pkg.sv]
// constants for the dual-clock 512x18 fifo with flags
package dcf_pkg;
	localparam int DCF_WIDTH = 18;
	localparam int DCF_AW    = 9;
	localparam int DCF_CW    = 10;
	localparam int DCF_TW    = 8;
	localparam int DCF_DEPTH = 512;

	localparam logic [9:0] DCF_CNT_FULL = 10'h200;
	localparam logic [9:0] DCF_CNT_HALF = 10'h100;
	localparam logic [9:0] DCF_CNT_ZERO = 10'h000;
	localparam logic [7:0] DCF_TH_DEF   = 8'h40;

	// synchroniser bit positions and idle pin levels
	localparam int SY_WCLK = 0;
	localparam int SY_RCLK = 1;
	localparam int SY_PEN  = 2;
	localparam int SY_RST  = 3;
	localparam int SY_OE   = 4;
	localparam int SY_N    = 5;
	localparam logic [4:0] SY_IDLE = 5'h1c;

	// wishbone map, byte addresses
	localparam int DCF_ADR_W = 4;
	localparam logic [3:0] ADR_CTRL = 4'h0;
	localparam logic [3:0] ADR_STAT = 4'h4;
	localparam logic [3:0] ADR_THR  = 4'h8;
	localparam int CTRL_CLR  = 0;
	localparam int STAT_EMPN = 0;
	localparam int STAT_FULN = 1;
	localparam int STAT_HALF = 2;
	localparam int STAT_ALM  = 3;
	localparam int STAT_CNT  = 16;
	localparam int THR_AE    = 0;
	localparam int THR_AF    = 8;
	localparam int THR_OPEN  = 16;

	typedef enum logic [3:0] {
		PG_FIRST  = 4'b0001,
		PG_SECOND = 4'b0010,
		PG_HOLD   = 4'b0100,
		PG_CLOSED = 4'b1000
	} dcf_prog_t;
endpackage

// [verif/dcf_checker.sv]
// port assertions for the fifo top
`timescale 1ns/1ps
module dcf_checker (
	// system
	input wire logic clk_i,
	input wire logic rst_i,
	// bus and enable
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic out_en_n_i,
	input wire logic ack_o,
	// flags
	input wire logic empty_n_o,
	input wire logic full_n_o,
	input wire logic half_flag_o,
	input wire logic almost_flag_o,
	input wire logic rd_word_oe_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_ack;
		ack_o ##1 !ack_o;
	endsequence
	a_ack_one: assert property (s_req |=> s_ack) else $error("ack not a single pulse");
	a_reset_vals: assert property ($fell(rst_i) |-> !empty_n_o && full_n_o
		&& !half_flag_o && almost_flag_o) else $error("flags wrong after reset");
	a_full_flags: assert property (!full_n_o |-> empty_n_o
		&& half_flag_o && almost_flag_o) else $error("flags wrong when full");
	a_empty_flags: assert property (!empty_n_o |-> full_n_o
		&& !half_flag_o && almost_flag_o) else $error("flags wrong when empty");
	a_first_word: assert property ($rose(empty_n_o) |-> full_n_o && !half_flag_o)
		else $error("first word flags");
	a_full_entry: assert property ($fell(full_n_o) |-> $past(half_flag_o))
		else $error("full without half");
	a_half_rise: assert property ($rose(half_flag_o) |-> empty_n_o && full_n_o)
		else $error("half rose at edge count");
	a_oe_on: assert property ($fell(out_en_n_i) |-> ##[2:4] rd_word_oe_o)
		else $error("outputs not enabled");
	a_oe_off: assert property ($rose(out_en_n_i) |-> ##[2:4] !rd_word_oe_o)
		else $error("outputs not released");
endmodule
bind dcf_fifo dcf_checker chk_u (.clk_i, .rst_i, .cyc_i, .stb_i, .out_en_n_i, .ack_o,
	.empty_n_o, .full_n_o, .half_flag_o, .almost_flag_o, .rd_word_oe_o);

// [verif/dcf_pins.sv]
// writer and reader pin model
`timescale 1ns/1ps
module dcf_pins (
	// system
	input  wire logic        clk_i,
	// pins toward the fifo
	output logic             wr_clk_o,
	output logic             rd_clk_o,
	output logic      [17:0] wr_word_o,
	output logic             prog_n_o
);
	initial begin
		wr_clk_o = 1'b0;
		rd_clk_o = 1'b0;
		wr_word_o = 18'h0;
		prog_n_o = 1'b1;
	end
	// edges at least 3 clk apart, enough for the 2 ff sync
	task automatic strobe(input logic wr, input logic rd, input logic pn, input logic [17:0] w);
		prog_n_o <= pn;
		wr_word_o <= w;
		repeat (3) @(posedge clk_i);
		wr_clk_o <= wr;
		rd_clk_o <= rd;
		repeat (3) @(posedge clk_i);
		wr_clk_o <= 1'b0;
		rd_clk_o <= 1'b0;
		// hold over, data no longer valid
		wr_word_o <= ~w;
		repeat (3) @(posedge clk_i);
	endtask
endmodule

// [verif/testbench.sv]
// self-checking bench for the fifo
`timescale 1ns/1ps
module testbench;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        fifo_rst_n_i = 1'b1;
	logic        out_en_n_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i = 1'b0;
	logic [3:0]  adr_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] rdat;
	logic        wr_clk_i;
	logic        rd_clk_i;
	logic        thresh_prog_n_i;
	logic [17:0] wr_word_i;
	logic [17:0] rd_word_o;
	logic        rd_word_oe_o;
	logic        empty_n_o;
	logic        full_n_o;
	logic        half_flag_o;
	logic        almost_flag_o;
	logic        ack_o;
	logic [31:0] dat_o;
	wire  [17:0] rd_bus = rd_word_oe_o ? rd_word_o : {18{1'bz}};
	wire  [31:0] flags = {28'h0, almost_flag_o, half_flag_o, full_n_o, empty_n_o};
	int          err_count = 0;
	int          tests_run = 0;
	int          ticks = 0;
	always #5 clk_i = ~clk_i;
	dcf_fifo dut_u (.clk_i, .rst_i, .wr_clk_i, .wr_word_i, .thresh_prog_n_i, .fifo_rst_n_i,
		.rd_clk_i, .out_en_n_i, .rd_word_o, .rd_word_oe_o, .empty_n_o, .full_n_o,
		.half_flag_o, .almost_flag_o, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'hf), .dat_i,
		.dat_o, .ack_o);
	dcf_pins pins_u (.clk_i, .wr_clk_o(wr_clk_i), .rd_clk_o(rd_clk_i), .wr_word_o(wr_word_i),
		.prog_n_o(thresh_prog_n_i));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		@(posedge clk_i);
		while (ack_o !== 1'b1) @(posedge clk_i);
		rdat = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	function automatic logic [31:0] fl(input int n, input int ae, input int af);
		return {28'h0, (n <= ae) || (n >= 512 - af), n >= 256, n != 512, n != 0};
	endfunction
	task automatic t_reset();
		chk(flags, fl(0, 64, 64));
		wb(1'b0, dcf_pkg::ADR_THR, 32'h0);
		chk(rdat, 32'h00014040);
		wb(1'b0, 4'hc, 32'h0);
		chk(rdat, 32'h0);
	endtask
	task automatic t_prog();
		pins_u.strobe(1'b1, 1'b0, 1'b0, 18'h3ff05);
		pins_u.strobe(1'b1, 1'b0, 1'b0, 18'h2aa03);
		wb(1'b0, dcf_pkg::ADR_STAT, 32'h0);
		chk(rdat, 32'h0000000a);
		wb(1'b0, dcf_pkg::ADR_THR, 32'h0);
		chk(rdat, 32'h00010305);
	endtask
	task automatic t_fill();
		out_en_n_i <= 1'b0;
		for (int n = 1; n <= 513; n++) begin
			pins_u.strobe(1'b1, 1'b0, 1'b1, 18'(n));
			chk(flags, fl(n > 512 ? 512 : n, 5, 3));
			chk({14'h0, rd_bus}, 32'h1);
		end
		wb(1'b0, dcf_pkg::ADR_STAT, 32'h0);
		chk(rdat, 32'h0200000d);
		wb(1'b0, dcf_pkg::ADR_THR, 32'h0);
		chk(rdat, 32'h00000305);
	endtask
	task automatic t_drain();
		for (int n = 511; n >= -1; n--) begin
			pins_u.strobe(1'b0, 1'b1, 1'b1, 18'h0);
			chk(flags, fl(n < 0 ? 0 : n, 5, 3));
			if (n > 0) chk({14'h0, rd_bus}, 32'(513 - n));
		end
	endtask
	task automatic t_pinrst();
		pins_u.strobe(1'b1, 1'b0, 1'b1, 18'h2a5a5);
		fifo_rst_n_i <= 1'b0;
		repeat (5) @(posedge clk_i);
		fifo_rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		chk(flags, fl(0, 64, 64));
		chk({14'h0, rd_bus}, 32'h2a5a5);
		wb(1'b0, dcf_pkg::ADR_THR, 32'h0);
		chk(rdat, 32'h00014040);
		pins_u.strobe(1'b1, 1'b0, 1'b1, 18'h1);
		pins_u.strobe(1'b1, 1'b0, 1'b0, 18'h0aa77);
		wb(1'b0, dcf_pkg::ADR_THR, 32'h0);
		chk(rdat, 32'h00004040);
		wb(1'b0, dcf_pkg::ADR_STAT, 32'h0);
		chk(rdat, 32'h0002000b);
		wb(1'b1, dcf_pkg::ADR_CTRL, 32'h1);
		wb(1'b0, dcf_pkg::ADR_STAT, 32'h0);
		chk(rdat, 32'h0000000a);
		out_en_n_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk({14'h0, rd_bus}, {14'h0, {18{1'bz}}});
	endtask
	task automatic results();
		if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		t_reset();
		t_prog();
		t_fill();
		t_drain();
		t_pinrst();
		results();
	end
	// ceiling well above the ten thousand cycles needed
	always @(posedge clk_i) begin
		ticks <= ticks + 1;
		if (ticks == 30000) begin
			err_count++;
			results();
		end
	end
endmodule
